// ==== rtl/adc_ctrl_regs.vh ====
// Constants for the converter control and result register block.
// Assumes inclusion by the design files below; definitions only.
// Contract
// R1 - Conversion result is a 24-bit register, readable only; writes do nothing.
// R2 - Control bit 23 chooses two's complement when set, offset binary when clear.
// R3 - Unipolar range gives straight binary output and ignores the coding bit.
// R4 - Bits 22..12 hold the filter code; word period is 512 times code clocks.
// R5 - Host programs filter code only between 10 and 2047 inclusive.
// R6 - One new output word per notch period.
// R7 - Bits 11..9 are the operating mode; reset loads self-calibration.
// R8 - Bit 8 set means bipolar, clear unipolar; reset sets it.
// R9 - Bits 7..5 gain; upper codes add post-filter multiply 2 to 16.
// R10 - Bit 4 enables the burn-out current source; reset clears it.
// R11 - Bit 3 standby halts filter, holds ready high, stops modulator clock.
// R12 - Leaving standby resumes as programmed, calibrating first if so set.
// R13 - Bit 2 set gives ascending byte order, clear descending; reset clears.
// R14 - Bit 1 clear gives MSB first, set LSB first; reset clears.
// R15 - Bit 0 set moves read data to the separate output line.
// R16 - Ready output goes low when a new valid result is present.
// R17 - A result read in progress keeps ready low and is never overwritten.
// R18 - A one-word buffer holds a result completed during an unfinished read.
// R19 - Host starts result read within one word period minus 128 clocks.
// R20 - Late read finish: result X+1 dropped, X+2 held in buffer.
// R21 - Read completion raises ready; buffered word moves in, ready after minimum high.
// R22 - Writing control byte 2 or 1 raises ready and recalibrates in calibration mode.
// R23 - Register select 00 is the result register, 01 the control register.
// R24 - Byte 0 is bits 7..0, byte 1 bits 15..8, byte 2 bits 23..16.
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH

`define REG_RESULT        2'h0
`define REG_CONTROL       2'h1
`define BYTE_0            2'h0
`define BYTE_1            2'h1
`define BYTE_2            2'h2

`define CTRL_CODING_BIT   23
`define CTRL_FILT_MSB     22
`define CTRL_FILT_LSB     12
`define CTRL_MODE_MSB     11
`define CTRL_MODE_LSB     9
`define CTRL_BIPOLAR_BIT  8
`define CTRL_GAIN_MSB     7
`define CTRL_GAIN_LSB     5
`define CTRL_BURNOUT_BIT  4
`define CTRL_STANDBY_BIT  3
`define CTRL_BYTEORD_BIT  2
`define CTRL_LSBFIRST_BIT 1
`define CTRL_SERLINE_BIT  0

`define MODE_CONVERT      3'h0
`define MODE_SELF_CAL     3'h1
`define FILT_CODE_RST     11'h0FA
`define CTRL_RST          {1'b0, `FILT_CODE_RST, `MODE_SELF_CAL, 1'b1, 3'h0, 5'h00}

`define DECIM_PER_CODE    10'h200
`define RDY_MIN_HIGH_CYC  8'h04

`endif

// ==== rtl/word_rate_timer.v ====
// Output word rate timer: one tick per 512 x filter code clocks.
// Assumes run and restart come from logic on the same clock.
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"
module word_rate_timer
(
  input  wire        clk,
  input  wire        rstn,
  input  wire        run,
  input  wire        restart,
  input  wire [10:0] code,
  output reg         tick
);
  reg  [9:0]  pre_r;
  reg  [10:0] cnt_r;
  wire        pre_end;
  wire        cnt_end;

  assign pre_end = (pre_r == (`DECIM_PER_CODE - 10'h001));
  // Code of zero would wrap to 2047 on the subtract; treated as one instead
  assign cnt_end = (cnt_r >= (code - 11'h001)) || (code == 11'h000);

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_r <= 10'h000;
      cnt_r <= 11'h000;
      tick  <= 1'b0;
    end
    else if (restart || !run)
    begin
      pre_r <= 10'h000;
      cnt_r <= 11'h000;
      tick  <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (pre_end)
      begin
        pre_r <= 10'h000;
        if (cnt_end)
        begin
          cnt_r <= 11'h000;
          tick  <= 1'b1; // see R4 see R6
        end
        else
          cnt_r <= cnt_r + 11'h001;
      end
      else
        pre_r <= pre_r + 10'h001;
    end
  end
endmodule // word_rate_timer

// ==== rtl/result_coder.v ====
// Post-filter digital multiply and output coding of one filter word.
// Assumes the filter word is two's complement in bipolar, unsigned in unipolar.
`timescale 1ns/1ps
module result_coder
(
  input  wire [23:0] raw,
  input  wire        bipolar,
  input  wire        twos_comp,
  input  wire [2:0]  gain_sel,
  output reg  [23:0] coded
);
  reg [2:0]  shift;
  reg [27:0] wide;
  reg [27:0] prod;
  reg [23:0] sat;

  always @*
  begin
    shift = 3'h0;
    if (gain_sel[2])
      shift = {1'b0, gain_sel[1:0]} + 3'h1; // see R9
    wide = bipolar ? {{4{raw[23]}}, raw} : {4'h0, raw};
    prod = wide << shift;
    // Saturate instead of wrapping so large inputs clip at full scale
    if (bipolar)
    begin
      if (prod[27:23] != {5{prod[27]}})
        sat = prod[27] ? 24'h800000 : 24'h7FFFFF;
      else
        sat = prod[23:0];
    end
    else
      sat = (prod[27:24] != 4'h0) ? 24'hFFFFFF : prod[23:0];
    coded = sat;
    if (bipolar && !twos_comp)
      coded = {~sat[23], sat[22:0]}; // see R2
    // Unipolar leaves the word straight binary whatever the coding bit says, see R3
  end
endmodule // result_coder

// ==== rtl/adc_register_core.v ====
// Control register, result register, one-word buffer and data-ready handshake.
// Assumes a serial instruction decoder on CLK_SYS supplies byte accesses and
// read start/done pulses, and a filter and calibrator on the same clock.
// Assumes the host keeps the filter code inside its legal range.
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"
module adc_register_core
(
  input  wire        CLK_SYS,
  input  wire        RSTN,
  input  wire [1:0]  REG_SEL,
  input  wire [1:0]  BYTE_SEL,
  input  wire        WR_STB,
  input  wire [7:0]  WR_DATA,
  output reg  [7:0]  RD_DATA,
  input  wire        RD_START,
  input  wire        RD_DONE,
  input  wire [23:0] FILTER_WORD,
  input  wire        CAL_DONE,
  output reg         CAL_START,
  output reg         RESULT_READY_N,
  output reg         MOD_CLK_EN,
  output reg         BURNOUT_EN,
  output reg  [2:0]  GAIN_SELECT,
  output reg  [2:0]  OPERATING_MODE,
  output reg         BYTE_ASCENDING,
  output reg         LSB_FIRST,
  output reg         READ_ON_OUT_LINE
);
  reg  [23:0] ctrl_r;
  reg  [23:0] ctrl_nxt;
  reg  [23:0] result_r;
  reg  [23:0] buffer_r;
  reg         buf_full_r;
  reg         ready_n_r;
  reg         pend_r;
  reg         reading_r;
  reg  [7:0]  high_cnt_r;
  reg         cal_req_r;
  reg         cal_busy_r;
  reg  [7:0]  rd_mux;

  wire        wr_ctrl;
  wire        wr_b0;
  wire        wr_reconfig;
  wire        standby;
  wire        sb_leave;
  wire        cal_mode_nxt;
  wire        run;
  wire        tick;
  wire        rd_done;
  wire        high_done;
  wire [23:0] coded;
  wire        rd_begin;
  wire        cal_trigger;
  wire        cal_cancel;
  wire        ready_out;

  assign wr_ctrl     = WR_STB && (REG_SEL == `REG_CONTROL); // see R23
  assign wr_b0       = wr_ctrl && (BYTE_SEL == `BYTE_0);
  assign wr_reconfig = wr_ctrl && ((BYTE_SEL == `BYTE_1) || (BYTE_SEL == `BYTE_2)); // see R22
  assign standby     = ctrl_r[`CTRL_STANDBY_BIT];
  assign sb_leave    = wr_b0 && standby && !WR_DATA[`CTRL_STANDBY_BIT];
  assign cal_mode_nxt = (ctrl_nxt[`CTRL_MODE_MSB:`CTRL_MODE_LSB] != `MODE_CONVERT);
  // Results only flow once any pending calibration has finished; the word
  // timer starts again from zero each time run returns
  assign run         = !standby && !cal_req_r && !cal_busy_r; // see R11 see R12
  assign rd_done     = RD_DONE && reading_r;
  assign high_done   = (high_cnt_r >= `RDY_MIN_HIGH_CYC);
  assign rd_begin    = RD_START && (REG_SEL == `REG_RESULT);
  // A request only counts in a calibration mode; leaving the mode drops it
  assign cal_trigger = (wr_reconfig || sb_leave) && cal_mode_nxt; // see R22 see R12
  assign cal_cancel  = cal_req_r && !ctrl_nxt[`CTRL_STANDBY_BIT] && !cal_mode_nxt;
  // Standby shows on the ready pin in the same cycle as the clock gate;
  // otherwise the modulator stops one clock before ready is released
  assign ready_out   = ready_n_r || standby; // see R11

  // Control register byte writes; each byte lands on its own, so a gain change
  // made through byte 0 alone triggers no recalibration
  always @*
  begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl)
    begin
      case (BYTE_SEL)
        `BYTE_0: ctrl_nxt[7:0]   = WR_DATA; // see R24
        `BYTE_1: ctrl_nxt[15:8]  = WR_DATA;
        `BYTE_2: ctrl_nxt[23:16] = WR_DATA;
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end

  always @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      ctrl_r <= `CTRL_RST; // see R2 see R7 see R8 see R9 see R10 see R13 see R14 see R15
    else
      ctrl_r <= ctrl_nxt;
  end

  // Calibration sequencing: reset starts in self-calibration mode
  // Any nonzero mode counts as a calibration mode
  always @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cal_req_r  <= 1'b1;
      cal_busy_r <= 1'b0;
      CAL_START  <= 1'b0;
    end
    else
    begin
      CAL_START <= 1'b0;
      if (cal_trigger || cal_cancel)
      begin
        // A new request restarts calibration; leaving the mode cancels it
        cal_req_r  <= cal_trigger; // see R22 see R12
        cal_busy_r <= 1'b0;
      end
      else if (cal_req_r && !standby)
      begin
        cal_req_r  <= 1'b0;
        cal_busy_r <= 1'b1;
        CAL_START  <= 1'b1;
      end
      else if (cal_busy_r && (CAL_DONE || standby))
        cal_busy_r <= 1'b0;
    end
  end

  word_rate_timer u_timer
  (
    .clk     (CLK_SYS),
    .rstn    (RSTN),
    .run     (run),
    .restart (wr_reconfig),
    .code    (ctrl_r[`CTRL_FILT_MSB:`CTRL_FILT_LSB]),
    .tick    (tick)
  );

  result_coder u_coder
  (
    .raw       (FILTER_WORD),
    .bipolar   (ctrl_r[`CTRL_BIPOLAR_BIT]),
    .twos_comp (ctrl_r[`CTRL_CODING_BIT]),
    .gain_sel  (ctrl_r[`CTRL_GAIN_MSB:`CTRL_GAIN_LSB]),
    .coded     (coded)
  );

  // Result read tracking; a read that starts in the cycle the previous one
  // ends is kept, the end only closes the older read
  always @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      reading_r <= 1'b0;
    else if (rd_begin)
      reading_r <= 1'b1;
    else if (RD_DONE)
      reading_r <= 1'b0;
  end

  // Minimum high time of the ready output, counted from each deassertion
  // The count stops at the threshold so it never wraps back below it
  always @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      high_cnt_r <= 8'h00;
    else if (rd_done || wr_reconfig || standby)
      high_cnt_r <= 8'h00;
    else if (ready_n_r && !high_done)
      high_cnt_r <= high_cnt_r + 8'h01;
  end

  // Result register, buffer and ready handshake. The word under read is never
  // touched; later words wait in the one-word buffer, and only the newest one
  // is kept there, so a host that reads too slowly loses the words in between.
  always @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      result_r   <= 24'h000000;
      buffer_r   <= 24'h000000;
      buf_full_r <= 1'b0;
      ready_n_r  <= 1'b1;
      pend_r     <= 1'b0;
    end
    else if (standby || wr_reconfig)
    begin
      // Queued words are dropped; the result register keeps its last value
      ready_n_r  <= 1'b1; // see R11 see R22
      pend_r     <= 1'b0;
      buf_full_r <= 1'b0;
    end
    else if (rd_done)
    begin
      // Finishing a read frees the result register for the queued word
      ready_n_r <= 1'b1; // see R21
      if (tick)
      begin
        // Newest word wins over a stale buffered one
        result_r   <= coded;
        pend_r     <= 1'b1;
        buf_full_r <= 1'b0;
      end
      else if (buf_full_r)
      begin
        result_r   <= buffer_r; // see R21
        pend_r     <= 1'b1;
        buf_full_r <= 1'b0;
      end
      else
        pend_r <= 1'b0;
    end
    else if (tick)
    begin
      if (reading_r)
      begin
        // Word under read stays put; an older buffered word is dropped
        buffer_r   <= coded; // see R17 see R18 see R20
        buf_full_r <= 1'b1;
      end
      // Host has not started reading: the newer word replaces the older one
      else if (!ready_n_r)
        result_r <= coded; // see R19
      else if (high_done)
      begin
        result_r  <= coded;
        ready_n_r <= 1'b0; // see R16
        pend_r    <= 1'b0;
      end
      else
      begin
        result_r <= coded;
        pend_r   <= 1'b1;
      end
    end
    else if (pend_r && high_done && !reading_r)
    begin
      ready_n_r <= 1'b0; // see R16 see R21
      pend_r    <= 1'b0;
    end
  end

  // Read data: result writes are simply not decoded
  // Unmapped registers and byte 3 read as zero
  always @*
  begin
    rd_mux = 8'h00;
    case (REG_SEL)
      `REG_RESULT:
      begin
        case (BYTE_SEL)
          `BYTE_0: rd_mux = result_r[7:0]; // see R1 see R24
          `BYTE_1: rd_mux = result_r[15:8];
          `BYTE_2: rd_mux = result_r[23:16];
          default: rd_mux = 8'h00;
        endcase
      end
      `REG_CONTROL:
      begin
        case (BYTE_SEL)
          `BYTE_0: rd_mux = ctrl_r[7:0];
          `BYTE_1: rd_mux = ctrl_r[15:8];
          `BYTE_2: rd_mux = ctrl_r[23:16];
          default: rd_mux = 8'h00;
        endcase
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // Registered outputs; field outputs lag the control register by one clock
  // so every top-level pin comes straight from a flip-flop
  always @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      RD_DATA          <= 8'h00;
      RESULT_READY_N   <= 1'b1;
      MOD_CLK_EN       <= 1'b0;
      BURNOUT_EN       <= 1'b0;
      GAIN_SELECT      <= 3'h0;
      OPERATING_MODE   <= `MODE_SELF_CAL;
      BYTE_ASCENDING   <= 1'b0;
      LSB_FIRST        <= 1'b0;
      READ_ON_OUT_LINE <= 1'b0;
    end
    else
    begin
      RD_DATA          <= rd_mux;
      RESULT_READY_N   <= ready_out; // see R11 see R16
      MOD_CLK_EN       <= !standby; // see R11
      BURNOUT_EN       <= ctrl_r[`CTRL_BURNOUT_BIT]; // see R10
      GAIN_SELECT      <= ctrl_r[`CTRL_GAIN_MSB:`CTRL_GAIN_LSB]; // see R9
      OPERATING_MODE   <= ctrl_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB]; // see R7
      BYTE_ASCENDING   <= ctrl_r[`CTRL_BYTEORD_BIT]; // see R13
      LSB_FIRST        <= ctrl_r[`CTRL_LSBFIRST_BIT]; // see R14
      READ_ON_OUT_LINE <= ctrl_r[`CTRL_SERLINE_BIT]; // see R15
    end
  end
endmodule // adc_register_core

// ==== verification/adc_register_core_monitor.sv ====
// Concurrent checks on the register core ports.
// Assumes bind from the bench; one clock domain, reset active low.
`timescale 1ns/1ps
module adc_register_core_monitor
(
  input wire       CLK_SYS,
  input wire       RSTN,
  input wire [1:0] REG_SEL,
  input wire [1:0] BYTE_SEL,
  input wire       WR_STB,
  input wire [7:0] WR_DATA,
  input wire [7:0] RD_DATA,
  input wire       RD_DONE,
  input wire       CAL_START,
  input wire       RESULT_READY_N,
  input wire       MOD_CLK_EN,
  input wire       BURNOUT_EN,
  input wire [2:0] GAIN_SELECT,
  input wire [2:0] OPERATING_MODE,
  input wire       BYTE_ASCENDING,
  input wire       LSB_FIRST,
  input wire       READ_ON_OUT_LINE
);
  wire wr0;
  wire wr1;
  wire wr2;
  assign wr0 = WR_STB && REG_SEL == 2'h1 && BYTE_SEL == 2'h0;
  assign wr1 = WR_STB && REG_SEL == 2'h1 && BYTE_SEL == 2'h1;
  assign wr2 = WR_STB && REG_SEL == 2'h1 && BYTE_SEL == 2'h2;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  a_standby_ready:
    assert property (!MOD_CLK_EN |-> RESULT_READY_N) else $error("ready low in standby");
  a_wr_standby:
    assert property (wr0 && WR_DATA[3] |-> ##2 !MOD_CLK_EN && RESULT_READY_N)
      else $error("standby write not obeyed");
  a_byte0_fields:
    assert property (wr0 |-> ##2 {GAIN_SELECT, BURNOUT_EN, BYTE_ASCENDING, LSB_FIRST,
      READ_ON_OUT_LINE} == {$past(WR_DATA[7:4], 2), $past(WR_DATA[2:0], 2)})
      else $error("low control fields wrong");
  a_mode_out:
    assert property (wr1 |-> ##2 OPERATING_MODE == $past(WR_DATA[3:1], 2))
      else $error("mode field wrong");
  a_reconf_ready:
    assert property (wr1 || wr2 |-> ##2 RESULT_READY_N) else $error("reconfig kept ready");
  a_cal_request:
    assert property (wr1 && WR_DATA[3:1] != 3'h0 && MOD_CLK_EN |-> ##[1:3] CAL_START)
      else $error("no calibration start");
  a_ready_holds:
    assert property (!RESULT_READY_N && !RD_DONE && !WR_STB && !$past(RD_DONE)
      && !$past(WR_STB) |=> !RESULT_READY_N) else $error("ready dropped early");
  a_rd_done_high:
    assert property (RD_DONE && !RESULT_READY_N |-> ##2 RESULT_READY_N)
      else $error("read end kept ready");
  a_min_high:
    assert property ($rose(RESULT_READY_N) |-> RESULT_READY_N[*3]) else $error("short high");
  a_unmapped_rd:
    assert property (REG_SEL[1] || BYTE_SEL == 2'h3 |=> RD_DATA == 8'h00)
      else $error("unmapped read not zero");
endmodule // adc_register_core_monitor

// ==== verification/cal_filter_model.sv ====
// Calibrator and filter stand-in facing the register core.
// Assumes the bench supplies the next filter word on word_in.
`timescale 1ns/1ps
module cal_filter_model
(
  input  wire        clk,
  input  wire        rstn,
  input  wire        cal_start,
  input  wire [23:0] word_in,
  output reg         cal_done,
  output wire [23:0] filter_word
);
  reg [5:0] cnt;
  // Only sampled on the core's word tick, so a plain follower is enough
  assign filter_word = word_in;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt      <= 6'h00;
      cal_done <= 1'b0;
    end
    else
    begin
      cal_done <= (cnt == 6'h01);
      if (cal_start)
        cnt <= 6'h28;
      else if (cnt != 6'h00)
        cnt <= cnt - 6'h01;
    end
  end
endmodule // cal_filter_model

// ==== verification/adc_register_core_bench.sv ====
// Self-checking bench for the register core.
// Assumes the core, its header and cal_filter_model compile alongside.
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"
module adc_register_core_bench;
  reg         clk_sys, rstn, wr_stb, rd_start, rd_done;
  reg  [1:0]  reg_sel, byte_sel;
  reg  [7:0]  wr_data;
  reg  [23:0] word_in, got;
  reg  [47:0] tbl [0:3];
  wire [23:0] filter_word;
  wire [7:0]  rd_data;
  wire [2:0]  gain, mode;
  wire        cal_done, cal_start, rdy_n, mclk_en, bo_en, asc, lsb, oline;
  integer     n_fail, cmp_count, i, k, cyc, t0;

  adc_register_core i_dut (.CLK_SYS(clk_sys), .RSTN(rstn), .REG_SEL(reg_sel),
    .BYTE_SEL(byte_sel), .WR_STB(wr_stb), .WR_DATA(wr_data), .RD_DATA(rd_data),
    .RD_START(rd_start), .RD_DONE(rd_done), .FILTER_WORD(filter_word),
    .CAL_DONE(cal_done), .CAL_START(cal_start), .RESULT_READY_N(rdy_n),
    .MOD_CLK_EN(mclk_en), .BURNOUT_EN(bo_en), .GAIN_SELECT(gain),
    .OPERATING_MODE(mode), .BYTE_ASCENDING(asc), .LSB_FIRST(lsb),
    .READ_ON_OUT_LINE(oline));
  cal_filter_model i_cal (.clk(clk_sys), .rstn(rstn), .cal_start(cal_start),
    .word_in(word_in), .cal_done(cal_done), .filter_word(filter_word));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc = cyc + 1;

  task step;
    @(posedge clk_sys);
    #1;
  endtask
  task check(input [23:0] seen, input [23:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task wr(input [1:0] r, input [1:0] b, input [7:0] d);
    reg_sel = r;
    byte_sel = b;
    wr_data = d;
    wr_stb = 1'b1;
    step;
    wr_stb = 1'b0;
    step;
  endtask
  task rd24(input [1:0] r);
    integer j;
    reg_sel = r;
    for (j = 0; j < 3; j = j + 1)
    begin
      byte_sel = j[1:0];
      step;
      got[8*j +: 8] = rd_data;
    end
  endtask
  task rstart;
    reg_sel = 2'h0;
    rd_start = 1'b1;
    step;
    rd_start = 1'b0;
  endtask
  task rdone;
    rd_done = 1'b1;
    step;
    rd_done = 1'b0;
    step;
    step;
    check(24'(rdy_n), 24'h1);
  endtask
  // Bounded at 12000 clocks, over two word periods of 5120 clocks
  task wait_rdy;
    k = 0;
    while (rdy_n !== 1'b0 && k < 12000)
    begin
      step;
      k = k + 1;
    end
    check(24'(rdy_n), 24'h0);
  endtask
  task give_verdict;
    $display("compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #4000000;
    n_fail = n_fail + 1;
    give_verdict;
  end

  initial
  begin
    {rstn, wr_stb, rd_start, rd_done, reg_sel, byte_sel, wr_data} = 16'h0000;
    word_in = 24'h000123;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    // Filter code 10, the shortest the host may program
    tbl[0] = 48'h00A100_800123;
    tbl[1] = 48'h80A100_000123;
    tbl[2] = 48'h00A000_000123;
    tbl[3] = 48'h80A180_000246;
    repeat (12) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    step;
    rd24(2'h1);
    check(got, {1'b0, `FILT_CODE_RST, `MODE_SELF_CAL, 1'b1, 8'h00});
    check(24'({rdy_n, mclk_en, mode, gain, bo_en, asc, lsb, oline}), 24'h000C80);
    rd24(2'h2);
    check(got, 24'h000000);
    $display("reset test done");
    wr(2'h1, 2'h0, 8'hF7);
    step;
    check(24'({gain, bo_en, asc, lsb, oline}), 24'h00007F);
    wr(2'h1, 2'h0, 8'h00);
    $display("field test done");
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(2'h1, 2'h2, tbl[i][47:40]);
      wr(2'h1, 2'h1, tbl[i][39:32]);
      wr(2'h1, 2'h0, tbl[i][31:24]);
      wait_rdy;
      rstart;
      rd24(2'h0);
      rdone;
      check(got, tbl[i][23:0]);
    end
    $display("coding test done");
    wait_rdy;
    t0 = cyc;
    rstart;
    rd24(2'h0);
    rdone;
    wr(2'h0, 2'h0, 8'h5A);
    wr(2'h0, 2'h2, 8'hA5);
    rd24(2'h0);
    check(got, 24'h000246);
    wait_rdy;
    check(24'(cyc - t0), 24'h001400);
    $display("rate test done");
    rstart;
    word_in = 24'h000200;
    repeat (5125) step;
    word_in = 24'h000300;
    repeat (5120) step;
    check(24'(rdy_n), 24'h0);
    rd24(2'h0);
    check(got, 24'h000246);
    rdone;
    wait_rdy;
    check(24'(k < 8), 24'h1);
    rstart;
    rd24(2'h0);
    rdone;
    check(got, 24'h000600);
    $display("buffer test done");
    wait_rdy;
    wr(2'h1, 2'h0, 8'h00);
    check(24'(rdy_n), 24'h0);
    wr(2'h1, 2'h0, 8'h08);
    step;
    check(24'({rdy_n, mclk_en}), 24'h2);
    repeat (6000) step;
    check(24'(rdy_n), 24'h1);
    wr(2'h1, 2'h0, 8'h00);
    wait_rdy;
    wr(2'h1, 2'h1, 8'hA3);
    check(24'(rdy_n), 24'h1);
    wait_rdy;
    $display("standby test done");
    give_verdict;
  end
endmodule // adc_register_core_bench

bind adc_register_core adc_register_core_monitor i_mon (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .REG_SEL(REG_SEL), .BYTE_SEL(BYTE_SEL), .WR_STB(WR_STB), .WR_DATA(WR_DATA),
  .RD_DATA(RD_DATA), .RD_DONE(RD_DONE), .CAL_START(CAL_START),
  .RESULT_READY_N(RESULT_READY_N), .MOD_CLK_EN(MOD_CLK_EN), .BURNOUT_EN(BURNOUT_EN),
  .GAIN_SELECT(GAIN_SELECT), .OPERATING_MODE(OPERATING_MODE),
  .BYTE_ASCENDING(BYTE_ASCENDING), .LSB_FIRST(LSB_FIRST),
  .READ_ON_OUT_LINE(READ_ON_OUT_LINE));
